// >>> hdl/wdh_ctrl.sv
// Watchdog timer with halt control, wake-up sequencing and reset causes
`default_nettype none
`include "wdh_cfg.svh"
// Operation
// RULE1: watchdog clock is the RC oscillator tick or system clock divided by four.
// RULE2: disabled watchdog ignores clear commands and never times out.
// RULE3: divider tap selectable among 2^12 to 2^15; overflow is timeout.
// RULE4: clear commands reset only the last two divider stages.
// RULE5: on instruction clock, the watchdog stops while halted.
// RULE6: overflow in normal operation gives chip reset and sets expired flag.
// RULE7: overflow while halted gives warm reset of program counter and stack pointer.
// RULE8: pin low, accepted clear or halt clears the watchdog count.
// RULE9: single mode clears on general command; dual mode needs both commands.
// RULE10: halt stops system oscillator, RC tick keeps running, state kept.
// RULE11: halt entry on RC clock clears the count and restarts it.
// RULE12: halt sets power-down, clears expired; general clear clears power-down.
// RULE13: halt ends on pin, interrupt, enabled port A fall or overflow.
// RULE14: port A or unserviceable interrupt wake resumes at next instruction.
// RULE15: requests already pending at halt entry cannot wake.
// RULE16: start-up delay of 1024 clocks after every reset and wake.
// RULE17: interrupt start comes a cycle after delay; next instruction immediately.
// RULE18: option-load delay on chip resets, not on wake from halt.
// RULE19: cause flags keep the documented values per reset kind.
// RULE20: chip reset holds watchdog clear, then lets it count.
// RULE21: expired and power-down flags are read-only to software.
module wdh_ctrl #(
	parameter int IRQ_N = 4,
	parameter int PORT_W = 8,
	parameter int SST_CYC = `WDH_SST_CYC,
	parameter int OPT_CYC = `WDH_OPT_LOAD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire wdh_pkg::wdh_cmd_t cmd,
	input wire logic master_init_pin_n,
	input wire logic rc_osc_tick,
	input wire logic [PORT_W-1:0] porta_in,
	input wire logic [IRQ_N-1:0] irq_req,
	input wire logic [IRQ_N-1:0] irq_en,
	input wire logic stack_full,
	output logic chip_reset,
	output logic warm_reset,
	output logic core_hold,
	output logic resume_next,
	output logic irq_resume,
	output logic sys_osc_run,
	output logic watchdog_expired_flag,
	output logic power_down_flag
);
	import wdh_pkg::*;

	localparam int CNT_W = 11;
	localparam int DIV_W = `WDH_DIV_W;

	wdh_state_t state;
	wdh_state_t next_state;
	logic [CNT_W-1:0] dly;
	logic [CNT_W-1:0] next_dly;
	logic [1:0] idiv;
	logic [DIV_W-1:0] pre;
	logic [1:0] fin;
	logic pend1;
	logic pend2;
	logic rst_seq;
	logic irq_pend;
	logic irq_dly;
	logic [IRQ_N-1:0] blocked;
	logic [PORT_W-1:0] porta_prev;
	logic wdt_en;
	logic clk_rc;
	logic [1:0] tap_sel;
	logic dual_mode;
	logic [PORT_W-1:0] wake_en;
	logic wr_pend;
	logic [7:0] wr_addr;

	// Register bus decode
	wire addr_ok = haddr[31:8] == 24'h0;
	wire bus_go = hsel && htrans[1] && hready;
	wire bus_rd = bus_go && !hwrite;
	wire sel_ctrl = addr_ok && haddr[7:0] == `WDH_REG_CTRL;
	wire sel_wake = addr_ok && haddr[7:0] == `WDH_REG_WAKE;
	wire sel_stat = addr_ok && haddr[7:0] == `WDH_REG_STATUS;
	wire sel_cnt = addr_ok && haddr[7:0] == `WDH_REG_COUNT;
	wire [31:0] ctrl_word = {27'h0, dual_mode, tap_sel, clk_rc, wdt_en};
	wire [31:0] stat_word = {28'h0, state == WDH_STARTUP,
		state == WDH_HALT, power_down_flag, watchdog_expired_flag};
	wire [31:0] cnt_word = {15'h0, fin, pre};
	wire [31:0] rd_word = sel_ctrl ? ctrl_word :
		sel_wake ? 32'(wake_en) :
		sel_stat ? stat_word :
		sel_cnt ? cnt_word : 32'h0;
	wire wr_ctrl = wr_pend && wr_addr == `WDH_REG_CTRL;
	wire wr_wake = wr_pend && wr_addr == `WDH_REG_WAKE;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Watchdog clock sources
	wire pin_low = !master_init_pin_n;
	wire running = state == WDH_RUN;
	wire halted = state == WDH_HALT;
	assign sys_osc_run = !halted; // see RULE10
	wire instr_tick = sys_osc_run && idiv == 2'(`WDH_INSTR_DIV - 1); // see RULE5
	wire wclk_en = wdt_en && (clk_rc ? rc_osc_tick : instr_tick); // see RULE1

	// Final two stages advance once per half of the selected ratio
	wire [DIV_W-1:0] tap_mask =
		DIV_W'((32'h1 << (`WDH_TAP_MIN - 1 + int'(tap_sel))) - 32'h1);
	wire tap_tick = wclk_en && (pre & tap_mask) == tap_mask; // see RULE3
	wire timeout = tap_tick && fin == 2'b11; // see RULE3

	// Clear commands only in normal execution
	wire gen_ok = running && wdt_en && !dual_mode // see RULE2
		&& cmd.general_watchdog_clear_cmd; // see RULE9
	wire any12 = cmd.first_watchdog_clear_cmd
		|| cmd.second_watchdog_clear_cmd;
	wire dual_ok = running && wdt_en && dual_mode && any12
		&& (pend1 || cmd.first_watchdog_clear_cmd)
		&& (pend2 || cmd.second_watchdog_clear_cmd); // see RULE9
	wire halt_go = running && cmd.halt_cmd && !pin_low && !timeout;
	wire in_reset = chip_reset;
	wire full_clr = pin_low || halt_go || in_reset; // see RULE8
	wire fin_clr = full_clr || gen_ok || dual_ok; // see RULE4

	// Wake sources
	wire [PORT_W-1:0] pa_fall = porta_prev & ~porta_in & wake_en;
	wire [IRQ_N-1:0] irq_new = irq_req & ~blocked; // see RULE15
	wire wake_ev = |pa_fall || |irq_new; // see RULE13
	wire wake_irq = |(irq_new & irq_en) && !stack_full; // see RULE14
	wire opt_done = state == WDH_OPTLOAD && dly == CNT_W'(OPT_CYC - 1);
	wire sst_done = state == WDH_STARTUP && dly == CNT_W'(SST_CYC - 1)
		&& !pin_low;

	assign chip_reset = state == WDH_HOLD || state == WDH_OPTLOAD
		|| (state == WDH_STARTUP && rst_seq); // see RULE20
	assign core_hold = !running;

	always_comb
	begin
		next_state = state;
		case (state)
			WDH_RUN:
			begin
				if (pin_low)
					next_state = WDH_HOLD;
				else if (timeout)
					next_state = WDH_OPTLOAD; // see RULE6
				else if (cmd.halt_cmd)
					next_state = WDH_HALT;
			end
			WDH_HALT:
			begin
				if (pin_low)
					next_state = WDH_HOLD;
				else if (timeout || wake_ev)
					next_state = WDH_STARTUP; // see RULE13
			end
			WDH_HOLD:
			begin
				if (!pin_low)
					next_state = WDH_OPTLOAD; // see RULE18
			end
			WDH_OPTLOAD:
			begin
				if (pin_low)
					next_state = WDH_HOLD;
				else if (opt_done)
					next_state = WDH_STARTUP;
			end
			WDH_STARTUP:
			begin
				if (pin_low)
					next_state = WDH_HOLD;
				else if (sst_done)
					next_state = WDH_RUN; // see RULE16
			end
			default:
				next_state = WDH_HOLD;
		endcase
	end

	always_comb
	begin
		if (next_state != state)
			next_dly = '0;
		else if (state == WDH_OPTLOAD || state == WDH_STARTUP)
			next_dly = dly + CNT_W'(1);
		else
			next_dly = dly;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= WDH_OPTLOAD;
			dly <= '0;
			rst_seq <= 1'b1;
		end
		else
		begin
			state <= next_state;
			dly <= next_dly;
			if (next_state == WDH_HOLD || next_state == WDH_OPTLOAD)
				rst_seq <= 1'b1;
			else if (next_state == WDH_RUN)
				rst_seq <= 1'b0;
		end
	end

	// Instruction clock divider stops with the system oscillator
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			idiv <= 2'h0;
		else if (sys_osc_run)
			idiv <= idiv + 2'h1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pre <= '0;
			fin <= 2'h0;
		end
		else
		begin
			if (full_clr)
				pre <= '0; // see RULE11
			else if (wclk_en)
				pre <= pre + DIV_W'(1);
			if (fin_clr)
				fin <= 2'h0; // see RULE8
			else if (tap_tick)
				fin <= fin + 2'h1;
		end
	end

	// Dual clear remembers which half has been seen
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pend1 <= 1'b0;
			pend2 <= 1'b0;
		end
		else if (dual_ok || in_reset)
		begin
			pend1 <= 1'b0;
			pend2 <= 1'b0;
		end
		else if (running && wdt_en && dual_mode)
		begin
			pend1 <= pend1 || cmd.first_watchdog_clear_cmd;
			pend2 <= pend2 || cmd.second_watchdog_clear_cmd;
		end
	end

	// Cause flags: only hardware events move them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			watchdog_expired_flag <= 1'b0; // see RULE19
			power_down_flag <= 1'b0;
		end
		else
		begin
			if (timeout && (running || halted) && !pin_low)
				watchdog_expired_flag <= 1'b1; // see RULE6
			else if (halt_go)
				watchdog_expired_flag <= 1'b0; // see RULE12
			if (halt_go)
				power_down_flag <= 1'b1; // see RULE12
			else if (gen_ok)
				power_down_flag <= 1'b0; // see RULE12
		end
	end

	// Wake bookkeeping and resume pulses
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			blocked <= '0;
			porta_prev <= '0;
			irq_pend <= 1'b0;
			warm_reset <= 1'b0;
			resume_next <= 1'b0;
			irq_dly <= 1'b0;
			irq_resume <= 1'b0;
		end
		else
		begin
			porta_prev <= porta_in;
			if (halt_go)
				blocked <= irq_req; // see RULE15
			warm_reset <= halted && timeout && !pin_low; // see RULE7
			if (halted && !pin_low && !timeout && wake_ev)
				irq_pend <= wake_irq; // see RULE14
			else if (state != WDH_HALT && state != WDH_STARTUP)
				irq_pend <= 1'b0;
			resume_next <= sst_done && !irq_pend; // see RULE17
			irq_dly <= sst_done && irq_pend;
			irq_resume <= irq_dly; // see RULE17
		end
	end

	// Bus slave: zero wait states, reads sampled in the address phase
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0;
			{dual_mode, tap_sel, clk_rc, wdt_en} <= `WDH_CTRL_RST;
			wake_en <= PORT_W'(`WDH_WAKE_RST);
		end
		else
		begin
			wr_pend <= bus_go && hwrite && addr_ok;
			wr_addr <= haddr[7:0];
			if (bus_rd)
				hrdata <= rd_word;
			if (wr_ctrl)
				{dual_mode, tap_sel, clk_rc, wdt_en} <= hwdata[4:0];
			if (wr_wake)
				wake_en <= hwdata[PORT_W-1:0];
		end
	end

	chk_sst_exit: assert property (@(posedge clk) disable iff (rst) // see RULE16
		sst_done |=> running && !core_hold)
		else $error("start-up delay did not end into execution");

	chk_sst_len: assert property (@(posedge clk) disable iff (rst) // see RULE16
		(running && !$past(running)) |-> $past(dly) == CNT_W'(SST_CYC - 1))
		else $error("execution resumed before full start-up delay");

	chk_halt_flags: assert property (@(posedge clk) disable iff (rst) // see RULE12
		halt_go |=> halted && power_down_flag && !watchdog_expired_flag
			&& !sys_osc_run)
		else $error("halt entry flags or oscillator wrong");

	chk_timeout_chip: assert property (@(posedge clk) disable iff (rst) // see RULE6
		(running && timeout && !pin_low) |=> chip_reset
			&& watchdog_expired_flag && state == WDH_OPTLOAD)
		else $error("normal timeout did not give chip reset");

	chk_warm_halt: assert property (@(posedge clk) disable iff (rst) // see RULE7
		(halted && timeout && !pin_low) |=> warm_reset && !chip_reset
			&& watchdog_expired_flag && power_down_flag ##1 !warm_reset)
		else $error("halt timeout did not give one warm reset");

	chk_halt_freeze: assert property (@(posedge clk) disable iff (rst) // see RULE5
		(halted && !clk_rc) |=> $stable(pre) || !halted)
		else $error("watchdog counted on stopped instruction clock");

	chk_disabled_quiet: assert property (@(posedge clk) disable iff (rst) // see RULE2
		!wdt_en |-> !timeout && !gen_ok && !dual_ok)
		else $error("disabled watchdog acted");

	chk_clear_stage: assert property (@(posedge clk) disable iff (rst) // see RULE4
		(gen_ok || dual_ok) && !full_clr |=> fin == 2'h0
			&& pre == $past(pre) + DIV_W'($past(wclk_en)))
		else $error("clear did not reset the last stages only");

	chk_irq_late: assert property (@(posedge clk) disable iff (rst) // see RULE17
		(sst_done && irq_pend) |=> !irq_resume && !resume_next
			##1 irq_resume)
		else $error("interrupt resume not one cycle after delay");

	chk_optload: assert property (@(posedge clk) disable iff (rst) // see RULE18
		(state == WDH_OPTLOAD) |-> chip_reset && core_hold)
		else $error("option load outside chip reset");
endmodule
`default_nettype wire

// >>> hdl/wdh_cfg.svh
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDH_CFG_SVH
`define WDH_CFG_SVH
`define WDH_REG_CTRL 8'h00
`define WDH_REG_WAKE 8'h04
`define WDH_REG_STATUS 8'h08
`define WDH_REG_COUNT 8'h0c
`define WDH_CTRL_EN 0
`define WDH_CTRL_RC 1
`define WDH_CTRL_TAP_LO 2
`define WDH_CTRL_DUAL 4
`define WDH_CTRL_RST 5'h03
`define WDH_WAKE_RST 8'h00
`define WDH_ST_EXPIRED 0
`define WDH_ST_PDOWN 1
`define WDH_ST_HALTED 2
`define WDH_ST_STARTUP 3
`define WDH_TAP_MIN 12
`define WDH_DIV_W 15
`define WDH_INSTR_DIV 4
`define WDH_SST_CYC 1024
`define WDH_OPT_LOAD_CYC 16
`endif

// >>> hdl/wdh_pkg.sv
// Types shared by the watchdog, halt and reset controller
`default_nettype none
package wdh_pkg;
	typedef enum logic [2:0] {
		WDH_RUN,
		WDH_HALT,
		WDH_HOLD,
		WDH_OPTLOAD,
		WDH_STARTUP
	} wdh_state_t;
	typedef struct packed {
		logic general_watchdog_clear_cmd;
		logic first_watchdog_clear_cmd;
		logic second_watchdog_clear_cmd;
		logic halt_cmd;
	} wdh_cmd_t;
endpackage
`default_nettype wire

// >>> tb/wdh_core_model.sv
// Processor core model that issues watchdog clear and halt commands
`default_nettype none
module wdh_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_hold,
	input wire logic [3:0] op,
	output var wdh_pkg::wdh_cmd_t cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	import wdh_pkg::*;
	// A held core executes nothing, so no command can leave it then
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cmd <= '0;
		else
			cmd <= core_hold ? '0 : wdh_cmd_t'(op);
	end
endmodule
`default_nettype wire

// >>> tb/watchdog_halt_reset_ctrl_tb_top.sv
// Self-checking bench for the watchdog, halt and reset controller
`default_nettype none
`include "wdh_cfg.svh"
module watchdog_halt_reset_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wdh_pkg::*;
	localparam int STARTUP_DELAY_TIMER = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic pin_n = 1'b1;
	logic [7:0] porta = 8'hff;
	logic [3:0] irq_req = '0;
	logic [3:0] irq_en = '0;
	logic [3:0] op = '0;
	logic rc_tick = 1'b1;
	logic stack_full = 1'b0;
	wire logic hreadyout, hresp, chip_reset, warm_reset, core_hold;
	wire logic resume_next, irq_resume, sys_osc_run, wd_exp, pd;
	wire logic [31:0] hrdata;
	wdh_cmd_t cmd;
	int fail_count = 0;
	int checks_done = 0;
	int n;
	logic [31:0] rd;
	always #4 clk = ~clk;
	// The RC tick runs every cycle so timeouts stay short
	wdh_ctrl #(.SST_CYC(STARTUP_DELAY_TIMER), .OPT_CYC(2)) DUT (.clk(clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd(cmd),
		.master_init_pin_n(pin_n), .rc_osc_tick(rc_tick), .porta_in(porta),
		.irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full),
		.chip_reset(chip_reset), .warm_reset(warm_reset),
		.core_hold(core_hold), .resume_next(resume_next),
		.irq_resume(irq_resume), .sys_osc_run(sys_osc_run),
		.watchdog_expired_flag(wd_exp), .power_down_flag(pd));
	wdh_core_model core (.clk(clk), .rst(rst), .core_hold(core_hold),
		.op(op), .cmd(cmd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic rdy();
		int i;
		@(posedge clk);
		for (i = 0; i < 50 && hreadyout !== 1'b1; i++)
			@(posedge clk);
		if (i == 50)
		begin
			fail_count++;
			test_done();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		rd = hrdata;
		chk(hresp, 0);
	endtask
	task automatic issue(input logic [3:0] v);
		@(posedge clk);
		op <= v;
		@(posedge clk);
		op <= '0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Leaves n at lim when the selected event never showed
	task automatic wait_sig(input int which, input int lim);
		logic [4:0] s;
		for (n = 0; n < lim; n++)
		begin
			@(posedge clk);
			#1;
			s = {irq_resume, resume_next, warm_reset, chip_reset, ~core_hold};
			if (s[which] === 1'b1)
				break;
		end
	endtask
	// An event that must come: running out of the bound ends the run
	task automatic wait_ev(input int which, input int lim);
		wait_sig(which, lim);
		if (n == lim)
		begin
			fail_count++;
			test_done();
		end
	endtask
	task automatic t_powerup();
		wait_ev(0, 100);
		chk({wd_exp, pd}, 2'b00);
		bus(0, `WDH_REG_CTRL, 0);
		chk(rd, `WDH_CTRL_RST);
		bus(0, `WDH_REG_WAKE, 0);
		chk(rd, `WDH_WAKE_RST);
		bus(0, 32'h40, 0);
		chk(rd, 0);
		bus(1, `WDH_REG_STATUS, 32'hf);
		bus(0, `WDH_REG_STATUS, 0);
		chk(rd, 0);
	endtask
	task automatic t_single_clear();
		repeat (3)
		begin
			wait_sig(1, 6000);
			chk(n, 6000);
			issue(4'h8);
		end
	endtask
	// A clear leaves the prescaler running, so the next timeout is partial
	task automatic t_dual_clear();
		bus(1, `WDH_REG_CTRL, 32'h13);
		issue(4'h4);
		issue(4'h2);
		wait_sig(1, 6000);
		chk(n, 6000);
		issue(4'h8);
		wait_ev(1, 2400);
		chk(n < 2400, 1);
		wait_ev(0, 100);
		chk({wd_exp, pd, sys_osc_run}, 3'b101);
		bus(1, `WDH_REG_CTRL, 32'h3);
	endtask
	task automatic t_pin_reset();
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({chip_reset, core_hold}, 2'b11);
		@(posedge clk);
		pin_n <= 1'b1;
		wait_ev(0, 100);
		chk({wd_exp, pd}, 2'b10);
	endtask
	task automatic t_port_wake();
		bus(1, `WDH_REG_WAKE, 32'h1);
		issue(4'h1);
		chk({core_hold, sys_osc_run, pd, wd_exp}, 4'b1010);
		@(posedge clk);
		porta <= 8'hfe;
		wait_ev(3, 50);
		chk(n, STARTUP_DELAY_TIMER);
		chk(chip_reset, 0);
		@(posedge clk);
		porta <= 8'hff;
		issue(4'h8);
		chk(pd, 0);
	endtask
	task automatic t_irq_wake();
		@(posedge clk);
		irq_en <= 4'h1;
		issue(4'h1);
		@(posedge clk);
		irq_req <= 4'h1;
		wait_ev(4, 50);
		chk(n < 50, 1);
		issue(4'h1);
		wait_sig(0, 40);
		chk(n, 40);
		@(posedge clk);
		porta <= 8'hfe;
		wait_ev(0, 50);
		chk(n < 50, 1);
		@(posedge clk);
		porta <= 8'hff;
		irq_req <= '0;
	endtask
	// Interrupt wake that cannot be serviced: disabled, then stack full
	task automatic t_irq_plain();
		int k;
		for (k = 0; k < 2; k++)
		begin
			@(posedge clk);
			irq_en <= 4'(k);
			stack_full <= k == 1;
			issue(4'h1);
			@(posedge clk);
			irq_req <= 4'h1;
			wait_ev(3, 50);
			chk(n, STARTUP_DELAY_TIMER);
			repeat (2) @(posedge clk);
			#1;
			chk(irq_resume, 0);
			@(posedge clk);
			irq_req <= '0;
		end
		stack_full <= 1'b0;
	endtask
	task automatic t_halt_timeout();
		issue(4'h1);
		wait_ev(2, 8400);
		chk({n < 8400, chip_reset}, 2'b10);
		wait_ev(0, 100);
		chk({wd_exp, pd}, 2'b11);
	endtask
	// Second tap doubles the time from a full clear to overflow
	task automatic t_tap_select();
		bus(1, `WDH_REG_CTRL, 32'h7);
		issue(4'h1);
		wait_sig(2, 16000);
		chk(n, 16000);
		wait_ev(2, 800);
		chk(n < 800, 1);
		wait_ev(0, 100);
		bus(1, `WDH_REG_CTRL, 32'h3);
	endtask
	// Forty cycles between two count samples, for each clock source
	task automatic t_clock_src();
		logic [31:0] r1;
		int k;
		int exp_n;
		for (k = 0; k < 3; k++)
		begin
			bus(1, `WDH_REG_CTRL, k == 1 ? 32'h1 : 32'h3);
			@(posedge clk);
			rc_tick <= k != 2;
			bus(0, `WDH_REG_COUNT, 0);
			r1 = rd;
			repeat (37) @(posedge clk);
			bus(0, `WDH_REG_COUNT, 0);
			exp_n = k == 2 ? 0 : k == 1 ? 40 / `WDH_INSTR_DIV : 40;
			chk(15'(rd[14:0] - r1[14:0]), exp_n);
		end
		@(posedge clk);
		rc_tick <= 1'b1;
		bus(1, `WDH_REG_CTRL, 32'h1);
		issue(4'h1);
		bus(0, `WDH_REG_COUNT, 0);
		chk(rd, 0);
		repeat (100) @(posedge clk);
		bus(0, `WDH_REG_COUNT, 0);
		chk(rd, 0);
		@(posedge clk);
		porta <= 8'hfe;
		wait_ev(0, 50);
		@(posedge clk);
		porta <= 8'hff;
	endtask
	task automatic t_disabled();
		bus(1, `WDH_REG_CTRL, 32'h2);
		issue(4'h8);
		wait_sig(1, 9000);
		chk(n, 9000);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_powerup();
		t_single_clear();
		t_dual_clear();
		t_pin_reset();
		t_port_wake();
		t_irq_wake();
		t_irq_plain();
		t_halt_timeout();
		t_tap_select();
		t_clock_src();
		t_disabled();
		test_done();
	end
endmodule
`default_nettype wire
